/* File: pms_consts.svh */
// Constants for the power mode sequencer: offsets, fields, reset values, timing
// Operation
// RQ1 - Wait 8 ms after supply up, sample mode pin, store mode status field.
// RQ2 - Pin high means master, grounded means slave, floating means self-work.
// RQ3 - Slave sets extended address bit 0 and turns internal reference off.
// RQ4 - Master and self-work hold power good low during start-up and shutdown.
// RQ5 - Slave floats power good, low after abnormal off until enable falls or restart.
// RQ6 - Rising enable while off starts power-on in factory rail order.
// RQ7 - Master holds power good low while off, releases 64 ms after last rail.
// RQ8 - Slave keeps power good floating through power-on unless a fault occurs.
// RQ9 - Rail not good within 32 ms: power good low, drop boot, wait again.
// RQ10 - With boot check set, power good not high within 128 ms aborts boot.
// RQ11 - Host pulls power good high through its own pull-up after power-on.
// RQ12 - Master and slave ignore external low on power good after power-on.
// RQ13 - Writing one to the restart bit restarts the power sequence.
// RQ14 - Shutdown bit, broadcast shutdown bit or falling enable starts normal off.
// RQ15 - Falling LDO input good while on starts abnormal off.
// RQ16 - Enabled DC-DC undervoltage while on starts abnormal off.
// RQ17 - Over-temperature with its enable set starts abnormal off.
// RQ18 - Rails go off in selected order, then discharge only if enabled.
// RQ19 - Master normal off: power good low, rails off, 4 ms gap if enabled.
// RQ20 - Abnormal off: power good low first, rails off after 4 ms.
// RQ21 - Slave normal off turns rails off without pulling power good low.
// RQ22 - Self-work defaults boot check, low restart, off delay on; others off.
// RQ23 - All delays are cycle counters on the system clock, cleared by reset.
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
`define PMS_CLK_HZ 10000000
`define PMS_T_POR_MS 8
`define PMS_T_RAIL_MS 32
`define PMS_T_PG_MS 64
`define PMS_T_BOOT_MS 128
`define PMS_T_OFF_MS 4
`define PMS_MS2CYC(ms) (((ms) * `PMS_CLK_HZ + 999) / 1000)
`define PMS_REG_STATUS 8'h00
`define PMS_REG_CTRL 8'h04
`define PMS_REG_OUTCFG 8'h08
`define PMS_REG_UVEN 8'h0c
`define PMS_REG_BCAST 8'h10
`define PMS_REG_RAILS 8'h14
`define PMS_B_SHUT 7
`define PMS_B_RESTART 6
`define PMS_B_BOOTCHK 5
`define PMS_B_PGRST 4
`define PMS_B_ORDER 3
`define PMS_B_OTEN 1
`define PMS_B_DISCH 3
`define PMS_B_OFFDLY 2
`define PMS_B_UV_LSB 3
`define PMS_RST_UVEN 5'h00
`define PMS_RESP_OKAY 2'h0
`define PMS_RESP_SLVERR 2'h2
`endif

/* File: pms_pkg.sv */
// Types of the power mode sequencer
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_WAIT_POR = 3'b000,
    PMS_OFF = 3'b001,
    PMS_ON_SEQ = 3'b010,
    PMS_SETTLE = 3'b011,
    PMS_BOOTCHK = 3'b100,
    PMS_ON = 3'b101,
    PMS_OFF_DLY = 3'b110,
    PMS_OFF_SEQ = 3'b111
  } pms_state_t;
  typedef enum logic [1:0] {
    PMS_MASTER = 2'b00,
    PMS_SLAVE = 2'b01,
    PMS_SELF = 2'b10
  } pms_mode_t;
endpackage

/* File: pms_sequencer.sv */
// Power mode sequencer with AXI4-Lite register slave
`include "pms_consts.svh"
module pms_sequencer #(
  parameter int N_RAIL = 5,
  parameter int unsigned T_POR_CYC = `PMS_MS2CYC(`PMS_T_POR_MS),
  parameter int unsigned T_RAIL_CYC = `PMS_MS2CYC(`PMS_T_RAIL_MS),
  parameter int unsigned T_PG_CYC = `PMS_MS2CYC(`PMS_T_PG_MS),
  parameter int unsigned T_BOOT_CYC = `PMS_MS2CYC(`PMS_T_BOOT_MS),
  parameter int unsigned T_OFF_CYC = `PMS_MS2CYC(`PMS_T_OFF_MS)
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic MODE_PIN_HIGH,
  input wire logic MODE_PIN_LOW,
  input wire logic ENABLE_OR_KEY_INPUT,
  input wire logic POWER_GOOD_OUT_IN,
  output logic POWER_GOOD_OUT_O,
  output logic POWER_GOOD_OUT_OE_N,
  input wire logic LDO_INPUT_GOOD,
  input wire logic [4:0] DCDC_UNDERVOLT,
  input wire logic OVERTEMP,
  input wire logic [N_RAIL-1:0] RAIL_GOOD,
  output logic [N_RAIL-1:0] RAIL_ENABLE,
  output logic DISCHARGE,
  output logic REF_ENABLE,
  output logic EXT_ADDR_BIT0,
  output pms_pkg::pms_state_t STATE
);
  import pms_pkg::*;

  localparam int IW = (N_RAIL > 1) ? $clog2(N_RAIL) : 1;
  localparam logic [IW-1:0] LAST = IW'(N_RAIL - 1);

  pms_state_t state, next_state;
  pms_mode_t mode;
  logic mode_valid;
  logic [20:0] cnt;
  logic [IW-1:0] idx;
  logic en_q, ldo_q, pg_fault, restart_pend, off_abn;
  logic boot_chk_en, pg_rst_en, order_sel, ot_en, disch_en, off_dly_en;
  logic [4:0] uv_en;
  logic aw_got, w_got;
  logic [7:0] aw_addr, w_data;
  logic w_lane0;
  logic wr_fire, wr_shut, wr_bcast, wr_restart;
  logic en_rise, en_fall, abn_src, norm_src, on_ish, rail_fail, boot_fail, step, cnt_clr, pg_low;
  logic [IW-1:0] off_rail;

  // AXI write: address and data taken in either order
  assign S_AXI_AWREADY = CE && !aw_got && !S_AXI_BVALID;
  assign S_AXI_WREADY = CE && !w_got && !S_AXI_BVALID;
  assign S_AXI_ARREADY = CE && !S_AXI_RVALID;
  assign wr_fire = CE && aw_got && w_got && !S_AXI_BVALID;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PMS_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA[7:0];
        w_lane0 <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr <= `PMS_REG_RAILS && aw_addr[1:0] == 2'h0) ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI read, status shows the block's live state
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `PMS_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `PMS_RESP_OKAY;
        case (S_AXI_ARADDR)
          `PMS_REG_STATUS: S_AXI_RDATA <= {24'h0, mode, pg_fault, POWER_GOOD_OUT_IN, restart_pend, state};
          `PMS_REG_CTRL: S_AXI_RDATA <= {24'h0, 2'h0, boot_chk_en, pg_rst_en, order_sel, 1'b0, ot_en, 1'b0};
          `PMS_REG_OUTCFG: S_AXI_RDATA <= {24'h0, 4'h0, disch_en, off_dly_en, 2'h0};
          `PMS_REG_UVEN: S_AXI_RDATA <= {24'h0, uv_en, 3'h0};
          `PMS_REG_BCAST: S_AXI_RDATA <= 32'h0000_0000;
          `PMS_REG_RAILS: S_AXI_RDATA <= 32'(RAIL_ENABLE);
          default: begin
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `PMS_RESP_SLVERR;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Command bits read back as zero, they act on write
  assign wr_shut = wr_fire && w_lane0 && aw_addr == `PMS_REG_CTRL && w_data[`PMS_B_SHUT];
  assign wr_restart = wr_fire && w_lane0 && aw_addr == `PMS_REG_CTRL && w_data[`PMS_B_RESTART];
  assign wr_bcast = wr_fire && w_lane0 && aw_addr == `PMS_REG_BCAST && w_data[`PMS_B_SHUT];

  // Configuration, defaults loaded when the mode is decided
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      boot_chk_en <= 1'b0;
      pg_rst_en <= 1'b0;
      off_dly_en <= 1'b0;
      order_sel <= 1'b0;
      ot_en <= 1'b0;
      disch_en <= 1'b0;
      uv_en <= `PMS_RST_UVEN;
    end else if (CE) begin
      if (state == PMS_WAIT_POR && next_state == PMS_OFF) begin
        // RQ22 mode defaults
        boot_chk_en <= MODE_PIN_LOW == MODE_PIN_HIGH && !MODE_PIN_HIGH;
        pg_rst_en <= MODE_PIN_LOW == MODE_PIN_HIGH && !MODE_PIN_HIGH;
        off_dly_en <= MODE_PIN_LOW == MODE_PIN_HIGH && !MODE_PIN_HIGH;
      end else if (wr_fire && w_lane0) begin
        if (aw_addr == `PMS_REG_CTRL) begin
          boot_chk_en <= w_data[`PMS_B_BOOTCHK];
          pg_rst_en <= w_data[`PMS_B_PGRST];
          order_sel <= w_data[`PMS_B_ORDER];
          ot_en <= w_data[`PMS_B_OTEN];
        end
        if (aw_addr == `PMS_REG_OUTCFG) begin
          disch_en <= w_data[`PMS_B_DISCH];
          off_dly_en <= w_data[`PMS_B_OFFDLY];
        end
        if (aw_addr == `PMS_REG_UVEN) begin
          uv_en <= w_data[`PMS_B_UV_LSB +: 5];
        end
      end
    end
  end

  // Mode capture after the start-up wait
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mode <= PMS_MASTER;
      mode_valid <= 1'b0;
      REF_ENABLE <= 1'b0;
      EXT_ADDR_BIT0 <= 1'b0;
    end else if (CE && state == PMS_WAIT_POR && next_state == PMS_OFF) begin
      mode_valid <= 1'b1;
      // RQ2 pin decode
      if (MODE_PIN_HIGH) begin
        mode <= PMS_MASTER;
      end else if (MODE_PIN_LOW) begin
        mode <= PMS_SLAVE;
      end else begin
        mode <= PMS_SELF;
      end
      // RQ3 address and reference
      EXT_ADDR_BIT0 <= !MODE_PIN_HIGH && MODE_PIN_LOW;
      REF_ENABLE <= !(!MODE_PIN_HIGH && MODE_PIN_LOW);
    end
  end

  // Event detection on synchronous inputs
  assign en_rise = ENABLE_OR_KEY_INPUT && !en_q;
  assign en_fall = !ENABLE_OR_KEY_INPUT && en_q;
  assign on_ish = state == PMS_SETTLE || state == PMS_BOOTCHK || state == PMS_ON;
  // RQ15 RQ16 RQ17 abnormal sources
  assign abn_src = (ldo_q && !LDO_INPUT_GOOD) || |(DCDC_UNDERVOLT & uv_en) || (OVERTEMP && ot_en);
  // RQ14 falling enable taken as the off edge
  assign norm_src = wr_shut || wr_bcast || en_fall;
  assign rail_fail = state == PMS_ON_SEQ && !RAIL_GOOD[idx] && cnt == 21'(T_RAIL_CYC - 1);
  assign boot_fail = state == PMS_BOOTCHK && !POWER_GOOD_OUT_IN && cnt == 21'(T_BOOT_CYC - 1);
  assign step = (state == PMS_ON_SEQ && RAIL_GOOD[idx]) || state == PMS_OFF_SEQ;
  assign cnt_clr = (next_state != state && !(state == PMS_SETTLE && next_state == PMS_BOOTCHK)) || step;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      en_q <= 1'b0;
      ldo_q <= 1'b0;
    end else if (CE) begin
      en_q <= ENABLE_OR_KEY_INPUT;
      ldo_q <= LDO_INPUT_GOOD;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      PMS_WAIT_POR: begin
        // RQ1 start-up wait
        if (cnt == 21'(T_POR_CYC - 1)) next_state = PMS_OFF;
      end
      PMS_OFF: begin
        // RQ6 power-on request
        if (en_rise || restart_pend) next_state = PMS_ON_SEQ;
      end
      PMS_ON_SEQ: begin
        if (RAIL_GOOD[idx] && idx == LAST) next_state = PMS_SETTLE;
        else if (rail_fail) next_state = PMS_OFF_SEQ;
      end
      PMS_OFF_DLY: begin
        // RQ20 delay before rails go off
        if (cnt == 21'(T_OFF_CYC - 1)) next_state = PMS_OFF_SEQ;
      end
      PMS_OFF_SEQ: begin
        if (idx == LAST) next_state = PMS_OFF;
      end
      default: begin
        if (abn_src) next_state = PMS_OFF_DLY;
        // RQ19 optional normal delay
        else if (norm_src) next_state = off_dly_en ? PMS_OFF_DLY : PMS_OFF_SEQ;
        // RQ13 restart goes through a full off
        else if (wr_restart) next_state = PMS_OFF_SEQ;
        // RQ12 external low only acts in self-work
        else if (state == PMS_ON && mode == PMS_SELF && pg_rst_en && !POWER_GOOD_OUT_IN) next_state = PMS_OFF_SEQ;
        // RQ7 release after 64 ms
        else if (state == PMS_SETTLE && cnt == 21'(T_PG_CYC - 1)) next_state = boot_chk_en ? PMS_BOOTCHK : PMS_ON;
        // RQ10 boot check window
        else if (state == PMS_BOOTCHK && POWER_GOOD_OUT_IN) next_state = PMS_ON;
        else if (boot_fail) next_state = PMS_OFF_SEQ;
      end
    endcase
  end

  // RQ23 one shared cycle counter
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state <= PMS_WAIT_POR;
      cnt <= 21'h0;
    end else if (CE) begin
      state <= next_state;
      cnt <= cnt_clr ? 21'h0 : cnt + 21'h1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      idx <= '0;
    end else if (CE) begin
      if (next_state != state) idx <= '0;
      else if (step) idx <= idx + IW'(1);
    end
  end

  // Fault latch and restart request; a new event wins over a clear
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pg_fault <= 1'b0;
      restart_pend <= 1'b0;
      off_abn <= 1'b0;
    end else if (CE) begin
      // RQ5 RQ9 fault holds power good low
      if ((on_ish && abn_src) || rail_fail) pg_fault <= 1'b1;
      else if (en_fall || wr_restart) pg_fault <= 1'b0;
      if (on_ish && !abn_src && !norm_src && (wr_restart || next_state == PMS_OFF_SEQ && state == PMS_ON && !boot_fail))
        restart_pend <= 1'b1;
      else if (state == PMS_OFF && next_state == PMS_ON_SEQ) restart_pend <= 1'b0;
      if (on_ish && next_state != state && next_state != PMS_BOOTCHK && next_state != PMS_ON) off_abn <= abn_src;
    end
  end

  // RQ18 off order: reverse of power-on, or same when selected
  assign off_rail = order_sel ? idx : LAST - idx;

  genvar gi;
  generate
    for (gi = 0; gi < N_RAIL; gi++) begin : g_rail
      always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
          RAIL_ENABLE[gi] <= 1'b0;
        end else if (CE) begin
          if (state == PMS_ON_SEQ && idx == IW'(gi)) RAIL_ENABLE[gi] <= 1'b1;
          else if (state == PMS_OFF_SEQ && off_rail == IW'(gi)) RAIL_ENABLE[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // RQ18 discharge set on the same edge that turns the last rail off
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      DISCHARGE <= 1'b0;
    end else if (CE) begin
      if (state == PMS_OFF_SEQ && next_state == PMS_OFF) DISCHARGE <= disch_en;
      else if (state == PMS_OFF && next_state == PMS_ON_SEQ) DISCHARGE <= 1'b0;
    end
  end

  // RQ4 RQ5 RQ8 RQ21 power good pull-down decode
  always_comb begin
    if (!mode_valid) pg_low = 1'b0;
    else if (mode == PMS_SLAVE) pg_low = pg_fault;
    else pg_low = !(state == PMS_BOOTCHK || state == PMS_ON) || pg_fault && state == PMS_OFF;
  end

  assign POWER_GOOD_OUT_O = 1'b0;
  assign POWER_GOOD_OUT_OE_N = !pg_low;
  assign STATE = state;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  AST_MODE_LATE: assert property (state == PMS_WAIT_POR |-> !mode_valid) else $error("mode set early"); // RQ1
  AST_MODE_TAKEN: assert property (CE && state == PMS_WAIT_POR && cnt == 21'(T_POR_CYC - 1) |=> mode_valid && state == PMS_OFF)
    else $error("mode not taken at 8 ms"); // RQ1
  AST_SLAVE_ADDR: assert property (mode_valid && mode == PMS_SLAVE |-> EXT_ADDR_BIT0 && !REF_ENABLE)
    else $error("slave address or reference wrong"); // RQ3
  AST_MASTER_OFF_LOW: assert property (mode_valid && mode != PMS_SLAVE && state == PMS_OFF |-> !POWER_GOOD_OUT_OE_N)
    else $error("power good not low while off"); // RQ7
  AST_SLAVE_FLOAT: assert property (mode == PMS_SLAVE && !pg_fault |-> POWER_GOOD_OUT_OE_N)
    else $error("slave drove power good"); // RQ8
  AST_ON_START: assert property (CE && state == PMS_OFF && en_rise |=> state == PMS_ON_SEQ)
    else $error("enable rise ignored"); // RQ6
  AST_RAIL_TIMEOUT: assert property (CE && rail_fail |=> state == PMS_OFF_SEQ && pg_fault)
    else $error("rail timeout not handled"); // RQ9
  AST_PG_IGNORED: assert property (CE && state == PMS_ON && mode != PMS_SELF && !abn_src && !norm_src && !wr_restart
    |=> state == PMS_ON) else $error("left on without cause"); // RQ12
  AST_ABN_HOLD: assert property (CE && on_ish && abn_src |=> state == PMS_OFF_DLY && $stable(RAIL_ENABLE)
    && !POWER_GOOD_OUT_OE_N) else $error("abnormal off not delayed"); // RQ20
  AST_OFF_EMPTY: assert property (state == PMS_OFF |-> RAIL_ENABLE == '0) else $error("rail on while off"); // RQ18

  COV_BOOT_OK: cover property (state == PMS_BOOTCHK ##1 state == PMS_ON);
  COV_ABN_OFF: cover property (state == PMS_OFF_DLY && off_abn ##1 state == PMS_OFF_SEQ);
  COV_RESTART: cover property (restart_pend && state == PMS_OFF ##1 state == PMS_ON_SEQ);
endmodule

/* File: pms_host.sv */
// Host-side model: enable driver, power-good pull-up and rail loads
module pms_host (
  input wire logic clk,
  input wire logic en_req,
  input wire logic pull_low,
  input wire logic [4:0] stuck,
  input wire logic pg_o,
  input wire logic pg_oe_n,
  input wire logic [4:0] rail_en,
  output logic en,
  output logic pg_line,
  output logic [4:0] rail_good
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pg_line = !pg_oe_n ? pg_o : !pull_low;
  assign en = en_req;
  // Stuck rails model a shorted load
  always @(posedge clk) rail_good <= rail_en & ~stuck;
endmodule

/* File: pmic_mode_power_sequencer_bench.sv */
// Self-checking bench of the power mode sequencer
`include "pms_consts.svh"
module pmic_mode_power_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pms_pkg::*;
  localparam int TP = 20, TR = 20, TG = 30, TB = 60, TO = 10;
  logic clk = 0, rstn = 0, mph = 1, mpl = 0, en_req = 0, pull_low = 0, ldo = 1, ot = 0, pglow = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv, en, pg, pgo, oen, dis, ref_en, xa;
  logic [4:0] uv = 5'h00, stuck = 5'h00, re, rg;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  pms_state_t st;
  int fails = 0, samples_checked = 0;
  pms_sequencer #(.T_POR_CYC(TP), .T_RAIL_CYC(TR), .T_PG_CYC(TG), .T_BOOT_CYC(TB), .T_OFF_CYC(TO)) i_dut (
    .CLK_SYS(clk), .RSTN(rstn), .CE(1'b1), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .MODE_PIN_HIGH(mph),
    .MODE_PIN_LOW(mpl), .ENABLE_OR_KEY_INPUT(en), .POWER_GOOD_OUT_IN(pg), .POWER_GOOD_OUT_O(pgo),
    .POWER_GOOD_OUT_OE_N(oen), .LDO_INPUT_GOOD(ldo), .DCDC_UNDERVOLT(uv), .OVERTEMP(ot), .RAIL_GOOD(rg),
    .RAIL_ENABLE(re), .DISCHARGE(dis), .REF_ENABLE(ref_en), .EXT_ADDR_BIT0(xa), .STATE(st));
  pms_host i_host (.clk(clk), .en_req(en_req), .pull_low(pull_low), .stuck(stuck), .pg_o(pgo), .pg_oe_n(oen),
    .rail_en(re), .en(en), .pg_line(pg), .rail_good(rg));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Handshakes are judged mid-cycle, where the combinational readies have settled
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ha, hw, hb;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    {awv, wv, bry} <= 3'b111;
    do begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr;
      hb = bv;
      r = bresp;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    logic ha, hr;
    @(posedge clk);
    araddr <= a;
    {arv, rry} <= 2'b11;
    do begin
      @(negedge clk);
      ha = arv && arr;
      hr = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arv <= 1'b0;
    end while (!hr);
    rry <= 1'b0;
  endtask
  task automatic wst(input pms_state_t s, input int n);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (oen === 1'b0) pglow = 1'b1;
    end while (st !== s && k < n);
    chk(st === s, "state not reached");
    @(posedge clk);
  endtask
  task automatic boot(input int m);
    mph <= (m == 0);
    mpl <= (m == 1);
    rstn <= 1'b0;
    cyc(10);
    rstn <= 1'b1;
    cyc(TP - 3);
    @(negedge clk);
    chk(st === PMS_WAIT_POR, "mode decided too early");
    wst(PMS_OFF, 10);
  endtask
  task automatic pon();
    en_req <= 1'b0;
    cyc(2);
    en_req <= 1'b1;
    wst(PMS_ON, 200);
  endtask
  // Waits for the first rail to drop, then judges delay, pin level and order
  task automatic offw(input logic dly, input logic pgl, input logic [4:0] first);
    int k;
    k = 0;
    while (re === 5'h1f && k < 60) begin
      @(negedge clk);
      k++;
      if (k == 2 && pgl) chk(oen === 1'b0, "pg not low before rails off");
    end
    chk(dly ? (k >= TO - 2) : (k <= 3), "off delay wrong");
    chk(re === first, "wrong first rail off");
    chk(oen === !pgl, "pg level during off");
    repeat (8) @(negedge clk);
    chk(re === 5'h00, "rails not off");
    @(posedge clk);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 3; m++) begin
      boot(m);
      axr(`PMS_REG_STATUS);
      chk(d[7:6] === m[1:0] && r === `PMS_RESP_OKAY, "mode status");
      chk(ref_en === (m != 1) && xa === (m == 1), "reference or address bit");
      chk(oen === (m == 1), "pg while off");
      axr(`PMS_REG_CTRL);
      chk(d[5] === (m == 2) && d[4] === (m == 2), "boot check default");
      axr(`PMS_REG_OUTCFG);
      chk(d[2] === (m == 2), "off delay default");
      // Self-work restarts on an external low by default
      if (m == 2) begin
        pon();
        pull_low <= 1'b1;
        wst(PMS_OFF_SEQ, 5);
        pull_low <= 1'b0;
        wst(PMS_ON, 200);
        en_req <= 1'b0;
      end
    end
    axr(8'h3c);
    chk(r === `PMS_RESP_SLVERR && d === 32'h0, "unmapped read");
    axw(8'h3c, 32'h80);
    chk(r === `PMS_RESP_SLVERR, "unmapped write");
  endtask
  task automatic t_master();
    int k;
    boot(0);
    en_req <= 1'b1;
    k = 0;
    while (re !== 5'h1f && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(oen === 1'b0, "pg not low in start-up");
    k = 0;
    while (oen !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(k >= TG && k <= TG + 4, "pg release time");
    @(posedge clk);
    pull_low <= 1'b1;
    cyc(20);
    @(negedge clk);
    chk(st === PMS_ON && re === 5'h1f, "reacted to external low");
    @(posedge clk);
    pull_low <= 1'b0;
    axr(`PMS_REG_RAILS);
    chk(d === 32'h1f && r === `PMS_RESP_OKAY, "rail readback");
    axw(`PMS_REG_CTRL, 32'h40);
    chk(r === `PMS_RESP_OKAY, "write response");
    wst(PMS_OFF_SEQ, 5);
    wst(PMS_ON, 200);
    axw(`PMS_REG_OUTCFG, 32'h4);
    axw(`PMS_REG_CTRL, 32'h80);
    offw(1, 1, 5'h0f);
    axw(`PMS_REG_OUTCFG, 32'h0);
    pon();
    axw(`PMS_REG_BCAST, 32'h80);
    offw(0, 1, 5'h0f);
    axw(`PMS_REG_CTRL, 32'h20);
    // Held-low line never lets the boot check finish
    pull_low <= 1'b1;
    en_req <= 1'b0;
    cyc(2);
    en_req <= 1'b1;
    wst(PMS_BOOTCHK, 100);
    wst(PMS_OFF, TB + 40);
    pull_low <= 1'b0;
  endtask
  task automatic t_abnormal();
    for (int i = 0; i < 3; i++) begin
      axw(`PMS_REG_CTRL, {28'h0, i[0], 3'b010});
      axw(`PMS_REG_OUTCFG, (i == 2) ? 32'h8 : 32'h0);
      axw(`PMS_REG_UVEN, 32'h8);
      pon();
      ldo <= (i != 0);
      uv <= {4'h0, i == 1};
      ot <= (i == 2);
      offw(1, 1, i[0] ? 5'h1e : 5'h0f);
      chk(dis === (i == 2), "discharge");
      {ldo, uv, ot} <= {1'b1, 5'h00, 1'b0};
    end
  endtask
  task automatic t_slave();
    boot(1);
    pglow = 1'b0;
    pon();
    chk(!pglow, "slave pg pulled in power-on");
    en_req <= 1'b0;
    offw(0, 0, 5'h0f);
    axw(`PMS_REG_UVEN, 32'h8);
    pon();
    uv <= 5'h01;
    offw(1, 1, 5'h0f);
    uv <= 5'h00;
    cyc(5);
    @(negedge clk);
    chk(oen === 1'b0, "fault pg not held");
    @(posedge clk);
    en_req <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk(oen === 1'b1, "fault pg not freed");
    @(posedge clk);
    stuck <= 5'h04;
    en_req <= 1'b1;
    cyc(TR + 20);
    @(negedge clk);
    chk(st === PMS_OFF && re === 5'h00 && oen === 1'b0, "rail timeout");
    @(posedge clk);
    stuck <= 5'h00;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    t_modes();
    t_master();
    t_abnormal();
    t_slave();
    report_and_stop();
  end
  // Whole run is under two thousand cycles
  initial begin
    #3000000;
    fails++;
    report_and_stop();
  end
endmodule
